/* File: include/ppfs_pkg.sv */
// ==========================================================================
// Shared constants and carriers
package ppfs_pkg;

  // ==========================================================================
  // Sizes
  localparam int NUM_PINS = 3;
  localparam int CFG_W = 8;
  localparam int DATA_W = 32;
  localparam int IDX_W = 16;
  localparam int ADDR_W = 18;
  localparam int NUM_IRQ = 2;
  localparam int NUM_IRQ_PINS = 2;

  // ==========================================================================
  // Register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_P4_6_CFG = 16'hA0D6;
  localparam logic [IDX_W-1:0] IDX_P4_7_CFG = 16'hA0D7;
  localparam logic [IDX_W-1:0] IDX_P5_0_CFG = 16'hA0D8;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 16'hA0F0;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 16'hA0F1;

  // ==========================================================================
  // Configuration fields
  localparam int LED_LINE_BIT = 7;
  localparam int ROUTE_BIT = 4;
  localparam int IRQ_B_SEL_BIT = 2;
  localparam int IRQ_A_SEL_BIT = 1;
  localparam int GENERAL_IO_BIT = 0;

  // Writable bits per pin, pin 0 is port 4 pin 6
  localparam logic [NUM_PINS-1:0][CFG_W-1:0] CFG_WMASK = {8'h91, 8'h97, 8'h97};
  localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;

  // ==========================================================================
  // Interrupt status layout
  localparam int ST_IRQ_A_BIT = 0;
  localparam int ST_IRQ_B_BIT = 1;

  // ==========================================================================
  // Per-pin drive sources
  typedef struct packed {
    logic led_seg;
    logic led_dig;
    logic periph_out;
    logic periph_oe_n;
    logic gpio_out;
    logic gpio_oe_n;
  } ppfs_pin_src_t;

  // Per-pin resolved drive
  typedef struct packed {
    logic out;
    logic oe_n;
  } ppfs_pin_drv_t;

  // ==========================================================================
  // Top-level state
  typedef struct packed {
    logic [NUM_PINS-1:0][CFG_W-1:0] cfg;
    logic [NUM_PINS-1:0] sync1;
    logic [NUM_PINS-1:0] sync2;
    logic [NUM_PINS-1:0] sync3;
    logic [NUM_PINS-1:0] filt;
    logic [NUM_IRQ-1:0] status;
    logic [NUM_IRQ-1:0] mask;
    logic irq;
    logic pin_irq_a;
    logic pin_irq_b;
    logic [NUM_PINS-1:0] pad_out;
    logic [NUM_PINS-1:0] pad_oe_n;
    logic [NUM_PINS-1:0] gpio_in;
    logic mosi_in;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } ppfs_state_t;

endpackage

/* File: hdl/ppfs_pin_mux.sv */
`timescale 1ns/1ps
// ==========================================================================
// One pin: fixed priority LED, peripheral, general I/O
module ppfs_pin_mux (
  input wire logic [ppfs_pkg::CFG_W-1:0] cfg,
  input wire logic led_digit_mode,
  input ppfs_pkg::ppfs_pin_src_t src,
  output ppfs_pkg::ppfs_pin_drv_t drv
);

  always_comb begin
    drv.out = 1'b0;
    drv.oe_n = 1'b1;
    if (cfg[ppfs_pkg::LED_LINE_BIT]) begin
      // LED segment or digit line
      drv.out = led_digit_mode ? src.led_dig : src.led_seg;
      drv.oe_n = 1'b0;
    end else if (cfg[ppfs_pkg::ROUTE_BIT]) begin
      // Peripheral route
      drv.out = src.periph_out;
      drv.oe_n = src.periph_oe_n;
    end else if (cfg[ppfs_pkg::GENERAL_IO_BIT]) begin
      // General I/O
      drv.out = src.gpio_out;
      drv.oe_n = src.gpio_oe_n;
    end
  end

endmodule

/* File: hdl/ppfs_top.sv */
// Register access over APB was decided locally.
`timescale 1ns/1ps
// Contract
// - Pin 4.6 bit 7 drives LED line 4
// - Pin 4.7 bit 7 drives LED line 6
// - Pin 5.0 bit 7 drives LED line 8
// - Pin 4.6 bit 4 routes first PWM
// - Pin 4.7 bit 4 routes second PWM
// - Pin 5.0 bit 4 connects SPI MOSI
// - Bit 2 feeds pin level to irq b; code: pins 4.6 and 4.7 only, pin 5.0 bit 2 not writable
// - Bit 1 feeds pin level to irq a; code: pins 4.6 and 4.7 only, pin 5.0 bit 1 not writable
// - Each pin interrupt ORs all selected pins
// - One pin may feed both interrupts
// - Bit 0 enables general I/O function
// - Registers reset to zero, functions off
// - Consecutive readable writable registers, unused bits zero
module ppfs_top #(
  parameter int NUM_PINS = ppfs_pkg::NUM_PINS,
  parameter int ADDR_W = ppfs_pkg::ADDR_W
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [ppfs_pkg::DATA_W-1:0] pwdata,
  output logic [ppfs_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic led_digit_mode,
  input ppfs_pkg::ppfs_pin_src_t [NUM_PINS-1:0] pin_src,
  input wire logic [NUM_PINS-1:0] pad_in,
  output logic [NUM_PINS-1:0] pad_out,
  output logic [NUM_PINS-1:0] pad_oe_n,
  output logic [NUM_PINS-1:0] gpio_in,
  output logic mosi_in,
  output logic pin_irq_a,
  output logic pin_irq_b,
  output logic irq
);

  // ==========================================================================
  // Elaboration checks
  if (NUM_PINS != ppfs_pkg::NUM_PINS) begin : g_bad_pins
    $error("ppfs_top serves exactly three pins");
  end
  if (ADDR_W < ppfs_pkg::IDX_W + 2) begin : g_bad_addr
    $error("ppfs_top address too narrow for the register map");
  end

  localparam logic [ppfs_pkg::NUM_PINS-1:0][ppfs_pkg::IDX_W-1:0] CFG_IDX = {
    ppfs_pkg::IDX_P5_0_CFG, ppfs_pkg::IDX_P4_7_CFG, ppfs_pkg::IDX_P4_6_CFG
  };

  localparam ppfs_pkg::ppfs_state_t STATE_RESET = '{
    cfg: {ppfs_pkg::NUM_PINS{ppfs_pkg::CFG_RESET}},
    sync1: '0,
    sync2: '0,
    sync3: '0,
    filt: '0,
    status: '0,
    mask: '0,
    irq: 1'b0,
    pin_irq_a: 1'b0,
    pin_irq_b: 1'b0,
    pad_out: '0,
    pad_oe_n: '1,
    gpio_in: '0,
    mosi_in: 1'b0,
    prdata: '0,
    pready: 1'b0,
    pslverr: 1'b0
  };

  ppfs_pkg::ppfs_state_t state_reg;
  ppfs_pkg::ppfs_state_t state_next;
  ppfs_pkg::ppfs_pin_drv_t [NUM_PINS-1:0] pin_drv;

  // ==========================================================================
  // Pin muxes
  for (genvar g = 0; g < NUM_PINS; g++) begin : g_mux
    ppfs_pin_mux ppfs_pin_mux_i (
      .cfg(state_reg.cfg[g]),
      .led_digit_mode(led_digit_mode),
      .src(pin_src[g]),
      .drv(pin_drv[g])
    );
  end

  // ==========================================================================
  // Next state
  always_comb begin
    logic [ppfs_pkg::IDX_W-1:0] word;
    logic aligned;
    logic setup;
    logic access;
    logic hit;
    logic cond_a;
    logic cond_b;
    logic [ppfs_pkg::NUM_IRQ-1:0] ev;
    logic [ppfs_pkg::NUM_IRQ-1:0] clr;
    word = paddr[ppfs_pkg::IDX_W+1:2];
    aligned = (paddr[1:0] == 2'h0);
    setup = psel && !penable;
    access = psel && penable && state_reg.pready;
    hit = 1'b0;
    cond_a = 1'b0;
    cond_b = 1'b0;
    ev = '0;
    clr = '0;
    state_next = state_reg;

    // Pad input synchroniser and agreement filter
    state_next.sync1 = pad_in;
    state_next.sync2 = state_reg.sync1;
    state_next.sync3 = state_reg.sync2;
    for (int i = 0; i < NUM_PINS; i++) begin
      if (state_reg.sync2[i] == state_reg.sync3[i]) begin
        state_next.filt[i] = state_reg.sync2[i];
      end
    end
    state_next.gpio_in = state_reg.filt;
    state_next.mosi_in = state_reg.filt[2] && state_reg.cfg[2][ppfs_pkg::ROUTE_BIT];

    // Shared pin interrupts
    for (int i = 0; i < ppfs_pkg::NUM_IRQ_PINS; i++) begin
      cond_a = cond_a | (state_reg.filt[i] & state_reg.cfg[i][ppfs_pkg::IRQ_A_SEL_BIT]);
      cond_b = cond_b | (state_reg.filt[i] & state_reg.cfg[i][ppfs_pkg::IRQ_B_SEL_BIT]);
    end
    state_next.pin_irq_a = cond_a;
    state_next.pin_irq_b = cond_b;
    ev[ppfs_pkg::ST_IRQ_A_BIT] = state_reg.pin_irq_a;
    ev[ppfs_pkg::ST_IRQ_B_BIT] = state_reg.pin_irq_b;

    // Pad drive from muxes
    for (int i = 0; i < NUM_PINS; i++) begin
      state_next.pad_out[i] = pin_drv[i].out;
      state_next.pad_oe_n[i] = pin_drv[i].oe_n;
    end

    // APB setup phase: read data and error
    state_next.pready = setup;
    if (setup) begin
      state_next.prdata = '0;
      state_next.pslverr = 1'b0;
      if (aligned) begin
        for (int k = 0; k < NUM_PINS; k++) begin
          if (word == CFG_IDX[k]) begin
            hit = 1'b1;
            state_next.prdata[ppfs_pkg::CFG_W-1:0] = state_reg.cfg[k];
          end
        end
        if (word == ppfs_pkg::IDX_IRQ_STATUS) begin
          hit = 1'b1;
          state_next.prdata[ppfs_pkg::NUM_IRQ-1:0] = state_reg.status;
        end
        if (word == ppfs_pkg::IDX_IRQ_MASK) begin
          hit = 1'b1;
          state_next.prdata[ppfs_pkg::NUM_IRQ-1:0] = state_reg.mask;
        end
      end
      state_next.pslverr = !hit;
    end

    // APB access phase: writes
    if (access && pwrite && aligned) begin
      for (int k = 0; k < NUM_PINS; k++) begin
        if (word == CFG_IDX[k]) begin
          state_next.cfg[k] = pwdata[ppfs_pkg::CFG_W-1:0] & ppfs_pkg::CFG_WMASK[k];
        end
      end
      if (word == ppfs_pkg::IDX_IRQ_STATUS) begin
        clr = pwdata[ppfs_pkg::NUM_IRQ-1:0];
      end
      if (word == ppfs_pkg::IDX_IRQ_MASK) begin
        state_next.mask = pwdata[ppfs_pkg::NUM_IRQ-1:0];
      end
    end

    // Sticky status, set wins over clear
    state_next.status = (state_reg.status & ~clr) | ev;
    state_next.irq = |(state_reg.status & state_reg.mask);
  end

  // ==========================================================================
  // State register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign pad_out = state_reg.pad_out;
  assign pad_oe_n = state_reg.pad_oe_n;
  assign gpio_in = state_reg.gpio_in;
  assign mosi_in = state_reg.mosi_in;
  assign pin_irq_a = state_reg.pin_irq_a;
  assign pin_irq_b = state_reg.pin_irq_b;
  assign irq = state_reg.irq;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_led_seg_a: assert property (
    state_reg.cfg[0][ppfs_pkg::LED_LINE_BIT] && !led_digit_mode
    |=> pad_out[0] == $past(pin_src[0].led_seg) && !pad_oe_n[0])
    else $error("pin 4.6 not driving LED segment");

  chk_led_dig_b: assert property (
    state_reg.cfg[1][ppfs_pkg::LED_LINE_BIT] && led_digit_mode
    |=> pad_out[1] == $past(pin_src[1].led_dig) && !pad_oe_n[1])
    else $error("pin 4.7 not driving LED digit");

  chk_led_line_c: assert property (
    state_reg.cfg[2][ppfs_pkg::LED_LINE_BIT]
    |=> pad_out[2] == ($past(led_digit_mode) ? $past(pin_src[2].led_dig)
                                              : $past(pin_src[2].led_seg)))
    else $error("pin 5.0 not driving LED line");

  chk_pwm_route_a: assert property (
    !state_reg.cfg[0][ppfs_pkg::LED_LINE_BIT] && state_reg.cfg[0][ppfs_pkg::ROUTE_BIT]
    |=> pad_out[0] == $past(pin_src[0].periph_out))
    else $error("pin 4.6 not carrying first PWM");

  chk_pwm_route_b: assert property (
    !state_reg.cfg[1][ppfs_pkg::LED_LINE_BIT] && state_reg.cfg[1][ppfs_pkg::ROUTE_BIT]
    |=> pad_out[1] == $past(pin_src[1].periph_out))
    else $error("pin 4.7 not carrying second PWM");

  chk_mosi_route: assert property (
    !state_reg.cfg[2][ppfs_pkg::LED_LINE_BIT] && state_reg.cfg[2][ppfs_pkg::ROUTE_BIT]
    |=> pad_oe_n[2] == $past(pin_src[2].periph_oe_n) && mosi_in == $past(state_reg.filt[2]))
    else $error("pin 5.0 not connected to MOSI");

  chk_irq_b_comb: assert property (
    ##1 pin_irq_b == $past(|(state_reg.filt[1:0]
      & {state_reg.cfg[1][ppfs_pkg::IRQ_B_SEL_BIT], state_reg.cfg[0][ppfs_pkg::IRQ_B_SEL_BIT]})))
    else $error("pin interrupt b condition wrong");

  chk_irq_a_comb: assert property (
    ##1 pin_irq_a == $past(|(state_reg.filt[1:0]
      & {state_reg.cfg[1][ppfs_pkg::IRQ_A_SEL_BIT], state_reg.cfg[0][ppfs_pkg::IRQ_A_SEL_BIT]})))
    else $error("pin interrupt a condition wrong");

  chk_irq_multi_pin: assert property (
    state_reg.filt[1] && state_reg.cfg[1][ppfs_pkg::IRQ_A_SEL_BIT]
    && state_reg.cfg[0][ppfs_pkg::IRQ_A_SEL_BIT] |=> pin_irq_a)
    else $error("second pin lost on interrupt a");

  chk_irq_both: assert property (
    state_reg.filt[0] && state_reg.cfg[0][ppfs_pkg::IRQ_A_SEL_BIT]
    && state_reg.cfg[0][ppfs_pkg::IRQ_B_SEL_BIT] |=> pin_irq_a && pin_irq_b)
    else $error("pin not feeding both interrupts");

  chk_gpio_drive: assert property (
    state_reg.cfg[0][ppfs_pkg::GENERAL_IO_BIT] && !state_reg.cfg[0][ppfs_pkg::LED_LINE_BIT]
    && !state_reg.cfg[0][ppfs_pkg::ROUTE_BIT]
    |=> pad_out[0] == $past(pin_src[0].gpio_out) && pad_oe_n[0] == $past(pin_src[0].gpio_oe_n))
    else $error("general I/O not driving pin");

  chk_reset_zero: assert property (
    disable iff (1'b0) !rst_n ##1 rst_n |-> state_reg.cfg == '0 && pad_oe_n == '1)
    else $error("configuration not zero after reset");

  chk_cfg_write: assert property (
    psel && penable && pready && pwrite && paddr == {CFG_IDX[2], 2'h0}
    |=> state_reg.cfg[2] == ($past(pwdata[ppfs_pkg::CFG_W-1:0]) & ppfs_pkg::CFG_WMASK[2]))
    else $error("pin 5.0 configuration write lost");

  chk_cfg_read: assert property (
    psel && !penable && !pwrite && paddr == {CFG_IDX[1], 2'h0}
    |=> pready && !pslverr && prdata == {24'h000000, $past(state_reg.cfg[1])})
    else $error("pin 4.7 configuration read wrong");

  chk_led_priority: assert property (
    state_reg.cfg[1][ppfs_pkg::LED_LINE_BIT] && state_reg.cfg[1][ppfs_pkg::ROUTE_BIT]
    && !led_digit_mode |=> pad_out[1] == $past(pin_src[1].led_seg) && !pad_oe_n[1])
    else $error("LED drive lost priority");

  chk_irq_level: assert property (
    ##1 irq == $past(|(state_reg.status & state_reg.mask)))
    else $error("interrupt output wrong");

  chk_status_set_a: assert property (
    state_reg.pin_irq_a |=> state_reg.status[ppfs_pkg::ST_IRQ_A_BIT])
    else $error("status a not set by pin interrupt a");

  chk_status_set_b: assert property (
    state_reg.pin_irq_b |=> state_reg.status[ppfs_pkg::ST_IRQ_B_BIT])
    else $error("status b not set by pin interrupt b");

  chk_pad_undriven: assert property (
    !state_reg.cfg[2][ppfs_pkg::LED_LINE_BIT] && !state_reg.cfg[2][ppfs_pkg::ROUTE_BIT]
    && !state_reg.cfg[2][ppfs_pkg::GENERAL_IO_BIT] |=> pad_oe_n[2] && !pad_out[2])
    else $error("pin 5.0 driven with no function selected");

endmodule

/* File: test/ppfs_top_tb_top.sv */
`timescale 1ns/1ps
// ====================================================
// Bench for the pin function block
`define CHK(got, exp) begin \
  checks++; \
  if ((got) !== (exp)) begin \
    err_count++; \
    $display("mismatch at %0t: got %h exp %h", $time, got, exp); \
  end \
end

module ppfs_top_tb_top;
  logic ref_clk, rst_n, psel, penable, pwrite, led_digit_mode;
  logic [ppfs_pkg::ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic pready, pslverr, mosi_in, pin_irq_a, pin_irq_b, irq;
  ppfs_pkg::ppfs_pin_src_t [2:0] pin_src;
  logic [2:0] pad_in, pad_out, pad_oe_n, gpio_in;
  logic [1:0] probe, st, msk;
  logic [7:0] cur [3];
  logic [32:0] rd_q [$];
  logic [6:0] pin_q [$];
  logic [32:0] rd_e;
  logic [6:0] pin_e;
  int err_count, checks;
  localparam logic [7:0] CV [8] = '{8'h80, 8'h80, 8'h10, 8'h01, 8'h00, 8'h91, 8'h11, 8'h95};
  localparam logic DM [8] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

  ppfs_top ppfs_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .led_digit_mode(led_digit_mode), .pin_src(pin_src), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe_n(pad_oe_n), .gpio_in(gpio_in), .mosi_in(mosi_in),
    .pin_irq_a(pin_irq_a), .pin_irq_b(pin_irq_b), .irq(irq));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // ====================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [17:0] ad(input logic [15:0] idx);
    return {idx, 2'b00};
  endfunction

  function automatic logic [5:0] exp_pads();
    logic [2:0] o, oe;
    for (int i = 0; i < 3; i++) begin
      if (cur[i][7]) begin
        o[i] = led_digit_mode ? pin_src[i].led_dig : pin_src[i].led_seg;
        oe[i] = 1'b0;
      end else if (cur[i][4]) begin
        o[i] = pin_src[i].periph_out;
        oe[i] = pin_src[i].periph_oe_n;
      end else if (cur[i][0]) begin
        o[i] = pin_src[i].gpio_out;
        oe[i] = pin_src[i].gpio_oe_n;
      end else begin
        o[i] = 1'b0;
        oe[i] = 1'b1;
      end
    end
    return {o, oe};
  endfunction

  task automatic stop_test();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ====================================================
  // Bus and probe drivers
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        err_count++;
        stop_test();
      end
      @(posedge ref_clk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] idx, input logic [32:0] e);
    rd_q.push_back(e);
    apb(1'b0, ad(idx), 32'h0000_0000);
  endtask

  task automatic wcfg(input int i, input logic [7:0] v);
    apb(1'b1, ad(16'(ppfs_pkg::IDX_P4_6_CFG + i)), {24'h00_0000, v});
    cur[i] = v & ((i == 2) ? 8'h91 : 8'h97);
  endtask

  task automatic probe_now(input logic [1:0] k, input logic [6:0] e);
    pin_q.push_back(e);
    @(posedge ref_clk);
    probe <= k;
    @(posedge ref_clk);
    probe <= 2'b00;
  endtask

  task automatic irq_probe();
    logic a, b;
    repeat (10) @(posedge ref_clk);
    a = |(pad_in[1:0] & {cur[1][1], cur[0][1]});
    b = |(pad_in[1:0] & {cur[1][2], cur[0][2]});
    st = st | {b, a};
    probe_now(2'b10, {pad_in, pad_in[2] & cur[2][4], a, b, |(st & msk)});
  endtask

  // ====================================================
  // Result watcher
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      rd_e = (rd_q.size() > 0) ? rd_q.pop_front() : 33'h0_DEAD_BEEF;
      `CHK({pslverr, prdata}, rd_e)
    end
    if (probe != 2'b00) begin
      pin_e = (pin_q.size() > 0) ? pin_q.pop_front() : 7'h7F;
      if (probe == 2'b01) begin
        `CHK({1'b0, pad_out, pad_oe_n}, pin_e)
      end else begin
        `CHK({gpio_in, mosi_in, pin_irq_a, pin_irq_b, irq}, pin_e)
      end
    end
  end

  // ====================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    led_digit_mode = 1'b0;
    pin_src = '0;
    pad_in = 3'b000;
    probe = 2'b00;
    rnd = 32'hEF69FFD9;
    st = 2'b00;
    msk = 2'b00;
    for (int i = 0; i < 3; i++) cur[i] = 8'h00;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    probe_now(2'b01, {1'b0, exp_pads()});
    for (int i = 0; i < 3; i++) rd(16'(ppfs_pkg::IDX_P4_6_CFG + i), 33'h0);
    rd(16'hA0D9, {1'b1, 32'h0000_0000});
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      wcfg(i, rnd[7:0] | 8'h6E);
      rd(16'(ppfs_pkg::IDX_P4_6_CFG + i), {25'h0, cur[i]});
    end
    for (int k = 0; k < 8; k++) begin
      for (int i = 0; i < 3; i++) begin
        rnd = lfsr(rnd);
        pin_src[i] <= ppfs_pkg::ppfs_pin_src_t'(rnd[5:0]);
        led_digit_mode <= DM[k];
        wcfg(i, CV[k]);
        repeat (2) @(posedge ref_clk);
        probe_now(2'b01, {1'b0, exp_pads()});
      end
    end
    // Interrupt source selection, status, mask and clear
    wcfg(0, 8'h07);
    wcfg(1, 8'h02);
    wcfg(2, 8'h10);
    apb(1'b1, ad(ppfs_pkg::IDX_IRQ_MASK), 32'h0000_0000);
    apb(1'b1, ad(ppfs_pkg::IDX_IRQ_STATUS), 32'h0000_0003);
    irq_probe();
    pad_in <= 3'b001;
    irq_probe();
    rd(ppfs_pkg::IDX_IRQ_STATUS, {31'h0, st});
    apb(1'b1, ad(ppfs_pkg::IDX_IRQ_MASK), 32'h0000_0003);
    msk = 2'b11;
    irq_probe();
    pad_in <= 3'b110;
    irq_probe();
    pad_in <= 3'b000;
    irq_probe();
    apb(1'b1, ad(ppfs_pkg::IDX_IRQ_STATUS), 32'h0000_0003);
    st = 2'b00;
    irq_probe();
    rd(ppfs_pkg::IDX_IRQ_STATUS, 33'h0);
    stop_test();
  end
endmodule
